// *** hdl/rqs_pkg.sv ***
// rqs_pkg: register map, field layout, timing and decode tables for reference qualification
package rqs_pkg;

   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam int          ADDR_W          = 8;
   localparam logic [7:0]  IDX_RANGE67     = 8'h19;
   localparam logic [7:0]  IDX_MASK0123    = 8'h1A;
   localparam logic [7:0]  IDX_MASK4567    = 8'h1B;
   localparam logic [7:0]  IDX_SOAK_TIME   = 8'h1C;
   localparam logic [7:0]  IDX_QUAL_STATUS = 8'h20;
   localparam logic [7:0]  ADDR_RANGE67     = 8'(IDX_RANGE67 * 4);
   localparam logic [7:0]  ADDR_MASK0123    = 8'(IDX_MASK0123 * 4);
   localparam logic [7:0]  ADDR_MASK4567    = 8'(IDX_MASK4567 * 4);
   localparam logic [7:0]  ADDR_SOAK_TIME   = 8'(IDX_SOAK_TIME * 4);
   localparam logic [7:0]  ADDR_QUAL_STATUS = 8'(IDX_QUAL_STATUS * 4);

   localparam logic [7:0]  RST_RANGE67   = 8'h33;
   localparam logic [7:0]  RST_MASK0123  = 8'hFF;
   localparam logic [7:0]  RST_MASK4567  = 8'hFF;
   localparam logic [7:0]  RST_SOAK_TIME = 8'h1A;

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int LIM_LO_POS   = 0;   // input6 range limit, bits 2:0
   localparam int LIM_HI_POS   = 4;   // input7 range limit, bits 6:4
   localparam int DROP_POS     = 0;   // drop delay select, bits 3:0
   localparam int REQUAL_POS   = 4;   // requalify multiple, bits 5:4
   localparam int MASK_SINGLE  = 0;   // low bit of each pair
   localparam int MASK_COARSE  = 1;   // high bit of each pair
   localparam int NUM_REFS     = 8;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 40;
   localparam int TICK_PERIOD_NS = 500_000;   // soak timer unit, 0.5 ms
   localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int UNIT_W         = 22;

   // ------------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [10:0] lo;   // lower limit, 0.1 ppm units
      logic [10:0] hi;   // upper limit, 0.1 ppm units
   } rqs_limit_s;

   typedef struct packed {
      logic [UNIT_W-1:0] dropUnits;     // 0.5 ms units
      logic [UNIT_W-1:0] requalUnits;   // 0.5 ms units
   } rqs_soak_cfg_s;

   // ------------------------------------------------------------------
   // decode tables
   // ------------------------------------------------------------------
   function automatic rqs_limit_s rangeLimit(input logic [2:0] code);
      rqs_limit_s r;
      r = '{lo: 11'h000, hi: 11'h000};
      unique case (code)
         3'h0: r = '{lo: 11'h05C, hi: 11'h078};
         3'h1: r = '{lo: 11'h190, hi: 11'h208};
         3'h2: r = '{lo: 11'h3E8, hi: 11'h514};
         3'h3: r = '{lo: 11'h280, hi: 11'h33E};
         3'h4: r = '{lo: 11'h08A, hi: 11'h0B4};
         3'h5: r = '{lo: 11'h0F6, hi: 11'h140};
         3'h6: r = '{lo: 11'h16E, hi: 11'h1DB};
         3'h7: r = '{lo: 11'h208, hi: 11'h2A3};
      endcase
      return r;
   endfunction

   // delay in 0.5 ms units; 6, A and E are filled in between neighbours
   function automatic logic [UNIT_W-1:0] dropUnits(input logic [3:0] code);
      logic [UNIT_W-1:0] u;
      u = '0;
      unique case (code)
         4'h0: u = 22'h000000;
         4'h1: u = 22'h000001;
         4'h2: u = 22'h000002;
         4'h3: u = 22'h00000A;
         4'h4: u = 22'h000014;
         4'h5: u = 22'h000064;
         4'h6: u = 22'h0001F4;
         4'h7: u = 22'h0003E8;
         4'h8: u = 22'h0007D0;
         4'h9: u = 22'h001388;
         4'hA: u = 22'h001770;
         4'hB: u = 22'h001F40;
         4'hC: u = 22'h003E80;
         4'hD: u = 22'h007D00;
         4'hE: u = 22'h00FA00;
         4'hF: u = 22'h01F400;
      endcase
      return u;
   endfunction

   function automatic logic [UNIT_W-1:0] requalUnits(input logic [UNIT_W-1:0] drop,
                                                    input logic [1:0]        mult);
      logic [UNIT_W-1:0] u;
      u = '0;
      unique case (mult)
         2'h0: u = UNIT_W'(drop << 1);
         2'h1: u = UNIT_W'(drop << 2);
         2'h2: u = UNIT_W'(drop << 4);
         2'h3: u = UNIT_W'(drop << 5);
      endcase
      return u;
   endfunction

endpackage

// *** hdl/rqs_soak_timer.sv ***
// rqs_soak_timer: per-reference guard soak timer driving the qualified flag
module rqs_soak_timer
   import rqs_pkg::*;
(
   input  wire logic          ref_clk,
   input  wire logic          rstn,
   input  wire logic          tick,
   input  wire logic          fault,
   input  wire rqs_soak_cfg_s cfg,
   output logic               qualified
);

   logic [UNIT_W-1:0] count;
   logic              pending;
   logic [UNIT_W-1:0] target;

   // ------------------------------------------------------------------
   // soak counting
   // ------------------------------------------------------------------
   assign pending = qualified ? fault : !fault;
   assign target  = qualified ? cfg.dropUnits : cfg.requalUnits;

   // any break in the condition restarts the soak
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         qualified <= 1'b1;
         count     <= '0;
      end
      else if (!pending)
         count <= '0;
      else if (count >= target)
      begin
         qualified <= !qualified;
         count     <= '0;
      end
      else if (tick)
         count <= count + UNIT_W'(1);
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   property p_zeroDelayDrop;
      @(posedge ref_clk) disable iff (!rstn)
      qualified && fault && cfg.dropUnits == '0 |=> !qualified;
   endproperty
   a_zeroDelayDrop: assert property (p_zeroDelayDrop)
      else $error("zero drop delay did not disqualify at once");

   property p_noEarlyDrop;
      @(posedge ref_clk) disable iff (!rstn)
      qualified && fault && cfg.dropUnits != '0 && count == '0 |=> qualified;
   endproperty
   a_noEarlyDrop: assert property (p_noEarlyDrop)
      else $error("reference dropped before its soak delay");

endmodule

// *** hdl/rqs_ref_qualify_soak_config.sv ***
// rqs_ref_qualify_soak_config: qualification config registers with monitor gating and soak

// Operation
// - each 3-bit range select picks the disqualify ppm window of the listed table.
// - each reference has a two-bit mask whose set bits stop a monitor feeding its soak timer.
// - in each pair the low bit gates the single-cycle check and the high bit the coarse check.
// - the first mask register holds references 0 to 3 in pairs 1:0, 3:2, 5:4 and 7:6.
// - the second mask register holds references 4 to 7 in rising pairs, reference 7 in 7:6.
// - bits 3:0 of the timer register choose the soak delay before a faulty input is dropped.
// - drop delay code 0000 drops the reference after the least delay the logic allows.
// - bits 5:4 make the requalify time 2, 4, 16 or 32 times the drop delay.
module rqs_ref_qualify_soak_config
   import rqs_pkg::*;
#(
   parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
   input  wire logic              ref_clk,
   input  wire logic              rstn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic [7:0]        coarseFrequencyCheck,
   input  wire logic [7:0]        singleCycleCheck,
   output rqs_limit_s             input6RangeLimit,
   output rqs_limit_s             input7RangeLimit,
   output logic [15:0]            monitorMask,
   output logic [7:0]             gatedFault,
   output logic [7:0]             refQualified
);

   localparam int TICK_W = $clog2(TICK_CYCLES_P + 1);

   if (TICK_CYCLES_P < 1)
      $error("TICK_CYCLES_P must be at least 1");

   // ------------------------------------------------------------------
   // register storage
   // ------------------------------------------------------------------
   logic [2:0]        input6RangeSel;
   logic [2:0]        input7RangeSel;
   logic [7:0]        maskLow;
   logic [7:0]        maskHigh;
   logic [3:0]        dropDelaySelect;
   logic [1:0]        requalifyMultiple;
   rqs_soak_cfg_s     soakCfg;

   // ------------------------------------------------------------------
   // write channel
   // ------------------------------------------------------------------
   logic              awHeld;
   logic              wHeld;
   logic [ADDR_W-1:0] awAddr;
   logic [7:0]        wByte;
   logic              wByteEn;
   logic              doWrite;
   logic              writeHit;

   assign s_axi_awready = !awHeld;
   assign s_axi_wready  = !wHeld;
   assign doWrite       = awHeld && wHeld && !s_axi_bvalid;
   assign writeHit      = awAddr == ADDR_RANGE67 || awAddr == ADDR_MASK0123
                          || awAddr == ADDR_MASK4567 || awAddr == ADDR_SOAK_TIME;

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         awHeld <= 1'b0;
         awAddr <= '0;
      end
      else if (s_axi_awvalid && !awHeld)
      begin
         awHeld <= 1'b1;
         awAddr <= s_axi_awaddr;
      end
      else if (doWrite)
         awHeld <= 1'b0;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         wHeld   <= 1'b0;
         wByte   <= '0;
         wByteEn <= 1'b0;
      end
      else if (s_axi_wvalid && !wHeld)
      begin
         wHeld   <= 1'b1;
         wByte   <= s_axi_wdata[7:0];
         wByteEn <= s_axi_wstrb[0];
      end
      else if (doWrite)
         wHeld <= 1'b0;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end
      else if (doWrite)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= writeHit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         input6RangeSel    <= RST_RANGE67[LIM_LO_POS +: 3];
         input7RangeSel    <= RST_RANGE67[LIM_HI_POS +: 3];
         maskLow           <= RST_MASK0123;
         maskHigh          <= RST_MASK4567;
         dropDelaySelect   <= RST_SOAK_TIME[DROP_POS +: 4];
         requalifyMultiple <= RST_SOAK_TIME[REQUAL_POS +: 2];
      end
      else if (doWrite && wByteEn)
      begin
         unique case (awAddr)
            ADDR_RANGE67:
            begin
               input6RangeSel <= wByte[LIM_LO_POS +: 3];
               input7RangeSel <= wByte[LIM_HI_POS +: 3];
            end
            ADDR_MASK0123:  maskLow  <= wByte;
            ADDR_MASK4567:  maskHigh <= wByte;
            ADDR_SOAK_TIME:
            begin
               dropDelaySelect   <= wByte[DROP_POS +: 4];
               requalifyMultiple <= wByte[REQUAL_POS +: 2];
            end
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // read channel
   // ------------------------------------------------------------------
   logic [7:0] readByte;
   logic       readHit;

   always_comb
   begin
      readByte = 8'h00;
      readHit  = 1'b1;
      unique case (s_axi_araddr)
         ADDR_RANGE67:     readByte = {1'b0, input7RangeSel, 1'b0, input6RangeSel};
         ADDR_MASK0123:    readByte = maskLow;
         ADDR_MASK4567:    readByte = maskHigh;
         ADDR_SOAK_TIME:   readByte = {2'b00, requalifyMultiple, dropDelaySelect};
         ADDR_QUAL_STATUS: readByte = refQualified;
         default:          readHit  = 1'b0;
      endcase
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RESP_OKAY;
      end
      else if (s_axi_arvalid && !s_axi_rvalid)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {24'h000000, readByte};
         s_axi_rresp  <= readHit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // ------------------------------------------------------------------
   // decoded outputs
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         input6RangeLimit <= rangeLimit(RST_RANGE67[LIM_LO_POS +: 3]);
         input7RangeLimit <= rangeLimit(RST_RANGE67[LIM_HI_POS +: 3]);
      end
      else
      begin
         input6RangeLimit <= rangeLimit(input6RangeSel);
         input7RangeLimit <= rangeLimit(input7RangeSel);
      end
   end

   assign monitorMask         = {maskHigh, maskLow};
   assign soakCfg.dropUnits   = dropUnits(dropDelaySelect);
   assign soakCfg.requalUnits = requalUnits(soakCfg.dropUnits, requalifyMultiple);

   // ------------------------------------------------------------------
   // soak tick and per-reference timers
   // ------------------------------------------------------------------
   logic [TICK_W-1:0] tickCount;
   logic              tick;

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         tickCount <= '0;
      else if (tickCount == TICK_W'(TICK_CYCLES_P - 1))
         tickCount <= '0;
      else
         tickCount <= tickCount + TICK_W'(1);
   end

   assign tick = tickCount == TICK_W'(TICK_CYCLES_P - 1);

   for (genvar k = 0; k < NUM_REFS; k++)
   begin : g_ref
      assign gatedFault[k] = (coarseFrequencyCheck[k] && !monitorMask[2*k + MASK_COARSE])
                             || (singleCycleCheck[k] && !monitorMask[2*k + MASK_SINGLE]);

      rqs_soak_timer u_timer (
         .ref_clk   (ref_clk),
         .rstn      (rstn),
         .tick      (tick),
         .fault     (gatedFault[k]),
         .cfg       (soakCfg),
         .qualified (refQualified[k])
      );
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   sequence s_writeAt(logic [ADDR_W-1:0] a);
      doWrite && wByteEn && awAddr == a;
   endsequence

   property p_limitWindow;
      @(posedge ref_clk) disable iff (!rstn)
      input6RangeSel == 3'h2 |=> input6RangeLimit.lo == 11'h3E8
                                 && input6RangeLimit.hi == 11'h514;
   endproperty
   a_limitWindow: assert property (p_limitWindow)
      else $error("range select 010 did not give 100-130 ppm");

   property p_maskBlocks;
      @(posedge ref_clk) disable iff (!rstn)
      monitorMask[1:0] == 2'b11 |-> !gatedFault[0];
   endproperty
   a_maskBlocks: assert property (p_maskBlocks)
      else $error("fully masked reference still reports a fault");

   property p_singleLowBit;
      @(posedge ref_clk) disable iff (!rstn)
      singleCycleCheck[0] && !monitorMask[0] |-> gatedFault[0];
   endproperty
   a_singleLowBit: assert property (p_singleLowBit)
      else $error("single-cycle fault not passed with low mask bit clear");

   property p_mask0Write;
      logic [7:0] d;
      @(posedge ref_clk) disable iff (!rstn)
      (s_writeAt(ADDR_MASK0123), d = wByte) |=> monitorMask[7:0] == d;
   endproperty
   a_mask0Write: assert property (p_mask0Write)
      else $error("first mask register write not applied");

   property p_mask1Write;
      logic [1:0] d;
      @(posedge ref_clk) disable iff (!rstn)
      (s_writeAt(ADDR_MASK4567), d = wByte[7:6]) |=> monitorMask[15:14] == d;
   endproperty
   a_mask1Write: assert property (p_mask1Write)
      else $error("reference 7 mask not in bits 7:6 of second mask register");

   property p_dropCode;
      @(posedge ref_clk) disable iff (!rstn)
      dropDelaySelect == 4'h1 |-> soakCfg.dropUnits == 22'h000001;
   endproperty
   a_dropCode: assert property (p_dropCode)
      else $error("drop delay 0001 is not 0.5 ms");

   property p_requalMult;
      @(posedge ref_clk) disable iff (!rstn)
      requalifyMultiple == 2'h3 |-> soakCfg.requalUnits == UNIT_W'(soakCfg.dropUnits * 32);
   endproperty
   a_requalMult: assert property (p_requalMult)
      else $error("requalify multiple 11 is not 32 times");

   property p_gapCode;
      @(posedge ref_clk) disable iff (!rstn)
      dropDelaySelect == 4'hA |-> soakCfg.dropUnits == 22'h001770;
   endproperty
   a_gapCode: assert property (p_gapCode)
      else $error("unlisted drop code 1010 is not 3 s");

endmodule

// *** sim/rqs_ref_qualify_soak_config_test.sv ***
// rqs_ref_qualify_soak_config_test: self-checking bench for the qualification config block
module rqs_ref_qualify_soak_config_test
   import rqs_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------------
   // signals and expectation tables
   // ------------------------------------------------------------------
   localparam int TP = 4;

   logic              ref_clk;
   logic              rstn;
   logic [ADDR_W-1:0] s_axi_awaddr;
   logic              s_axi_awvalid;
   logic              s_axi_awready;
   logic [31:0]       s_axi_wdata;
   logic [3:0]        s_axi_wstrb;
   logic              s_axi_wvalid;
   logic              s_axi_wready;
   logic [1:0]        s_axi_bresp;
   logic              s_axi_bvalid;
   logic              s_axi_bready;
   logic [ADDR_W-1:0] s_axi_araddr;
   logic              s_axi_arvalid;
   logic              s_axi_arready;
   logic [31:0]       s_axi_rdata;
   logic [1:0]        s_axi_rresp;
   logic              s_axi_rvalid;
   logic              s_axi_rready;
   logic [7:0]        coarseFrequencyCheck;
   logic [7:0]        singleCycleCheck;
   rqs_limit_s        input6RangeLimit;
   rqs_limit_s        input7RangeLimit;
   logic [15:0]       monitorMask;
   logic [7:0]        gatedFault;
   logic [7:0]        refQualified;
   int                miscompares;
   int                testsRun;
   logic [1:0]        resp;
   logic [31:0]       data;
   // window limits in 0.1 ppm
   logic [10:0]       limLo [8] = '{11'h05C, 11'h190, 11'h3E8, 11'h280,
                                    11'h08A, 11'h0F6, 11'h16E, 11'h208};
   logic [10:0]       limHi [8] = '{11'h078, 11'h208, 11'h514, 11'h33E,
                                    11'h0B4, 11'h140, 11'h1DB, 11'h2A3};

   rqs_ref_qualify_soak_config #(.TICK_CYCLES_P(TP)) dut_u
   (
      .ref_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .coarseFrequencyCheck,
      .singleCycleCheck, .input6RangeLimit, .input7RangeLimit, .monitorMask,
      .gatedFault, .refQualified
   );

   // ------------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------------
   task automatic checkWord(input string name, input logic [31:0] exp, input logic [31:0] got);
      testsRun++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic finalReport();
      $display("comparisons %0d mismatches %0d", testsRun, miscompares);
      if (miscompares == 0 && testsRun > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   function automatic logic [31:0] limExp(input logic [2:0] c);
      return {10'h000, limLo[c], limHi[c]};
   endfunction

   task automatic settle();
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask

   task automatic axiWrite(input logic [7:0] a, input logic [7:0] d);
      logic aw;
      logic w;
      aw = 1'b1;
      w = 1'b1;
      @(posedge ref_clk);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= {24'h000000, d};
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (aw || w)
      begin
         @(posedge ref_clk);
         if (aw && s_axi_awready === 1'b1)
         begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready === 1'b1)
         begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic axiRead(input logic [7:0] a);
      @(posedge ref_clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
      data = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic readCheck(input string name, input logic [7:0] a, input logic [7:0] exp,
                            input logic [1:0] r);
      axiRead(a);
      checkWord(name, {24'h000000, exp}, data);
      checkWord({name, " resp"}, {30'h0, r}, {30'h0, resp});
   endtask

   // waits for ref0 to reach lvl; t ticks of TP cycles, free-running tick phase
   task automatic measure(input int t, input logic lvl, input string name);
      int n;
      n = 0;
      while (refQualified[0] !== lvl && n < t * TP + 12)
      begin
         @(posedge ref_clk);
         n++;
      end
      checkWord(name, 32'h1, {31'h0, n >= (t > 0 ? (t - 1) * TP : 1) && n <= t * TP + 4});
   endtask

   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   task automatic testResetValues();
      readCheck("range reg", ADDR_RANGE67, 8'h33, RESP_OKAY);
      readCheck("mask0 reg", ADDR_MASK0123, 8'hFF, RESP_OKAY);
      readCheck("mask1 reg", ADDR_MASK4567, 8'hFF, RESP_OKAY);
      readCheck("timer reg", ADDR_SOAK_TIME, 8'h1A, RESP_OKAY);
      readCheck("status reg", ADDR_QUAL_STATUS, 8'hFF, RESP_OKAY);
      checkWord("reset limit", limExp(3'h3), {10'h000, input6RangeLimit});
      checkWord("reset mask", 32'h0000FFFF, {16'h0000, monitorMask});
      readCheck("unmapped read", 8'h40, 8'h00, RESP_SLVERR);
      axiWrite(8'h44, 8'h5A);
      checkWord("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
      s_axi_wstrb <= 4'hE;
      axiWrite(ADDR_MASK4567, 8'h00);
      s_axi_wstrb <= 4'hF;
      checkWord("strobe off resp", {30'h0, RESP_OKAY}, {30'h0, resp});
      readCheck("strobe off mask1", ADDR_MASK4567, 8'hFF, RESP_OKAY);
      axiWrite(ADDR_SOAK_TIME, 8'hFF);
      readCheck("timer reserved", ADDR_SOAK_TIME, 8'h3F, RESP_OKAY);
   endtask

   task automatic testRangeLimits();
      logic [2:0] c;
      for (int k = 0; k < 8; k++)
      begin
         c = 3'(k);
         axiWrite(ADDR_RANGE67, {1'b1, ~c, 1'b1, c});
         checkWord("write resp", {30'h0, RESP_OKAY}, {30'h0, resp});
         settle();
         checkWord("input6 limit", limExp(c), {10'h000, input6RangeLimit});
         checkWord("input7 limit", limExp(~c), {10'h000, input7RangeLimit});
         readCheck("range readback", ADDR_RANGE67, {1'b0, ~c, 1'b0, c}, RESP_OKAY);
      end
   endtask

   task automatic testMasks();
      logic [15:0] m;
      logic [7:0]  exp;
      // every pair value appears once in each register
      m = 16'hE41B;
      axiWrite(ADDR_MASK0123, m[7:0]);
      axiWrite(ADDR_MASK4567, m[15:8]);
      readCheck("mask0 readback", ADDR_MASK0123, m[7:0], RESP_OKAY);
      readCheck("mask1 readback", ADDR_MASK4567, m[15:8], RESP_OKAY);
      checkWord("monitor mask", {16'h0000, m}, {16'h0000, monitorMask});
      for (int p = 0; p < 4; p++)
      begin
         @(posedge ref_clk);
         coarseFrequencyCheck <= {8{p[0]}};
         singleCycleCheck     <= {8{p[1]}};
         settle();
         for (int k = 0; k < 8; k++)
            exp[k] = (p[0] & ~m[2 * k + 1]) | (p[1] & ~m[2 * k]);
         checkWord("gated fault", {24'h000000, exp}, {24'h000000, gatedFault});
      end
      @(posedge ref_clk);
      coarseFrequencyCheck <= 8'h00;
      singleCycleCheck     <= 8'h00;
   endtask

   task automatic testSoak();
      logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6};
      int         drop [5]  = '{0, 1, 2, 10, 500};
      int         mult [4]  = '{2, 4, 16, 32};
      logic [1:0] m;
      axiWrite(ADDR_MASK0123, 8'h00);
      for (int k = 0; k < 5; k++)
      begin
         m = 2'(k % 4);
         axiWrite(ADDR_SOAK_TIME, {2'h0, m, codes[k]});
         readCheck("timer readback", ADDR_SOAK_TIME, {2'h0, m, codes[k]}, RESP_OKAY);
         @(posedge ref_clk);
         singleCycleCheck <= 8'h01;
         measure(drop[k], 1'b0, "drop time");
         readCheck("status dropped", ADDR_QUAL_STATUS, 8'hFE, RESP_OKAY);
         @(posedge ref_clk);
         singleCycleCheck <= 8'h00;
         measure(drop[k] * mult[m], 1'b1, "requalify time");
      end
   endtask

   // ------------------------------------------------------------------
   // clock, watchdog and main sequence
   // ------------------------------------------------------------------
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   initial
   begin
      repeat (30000) @(posedge ref_clk);
      miscompares++;
      finalReport();
   end

   initial
   begin
      miscompares          = 0;
      testsRun             = 0;
      rstn                 = 1'b0;
      s_axi_awaddr         = 8'h00;
      s_axi_awvalid        = 1'b0;
      s_axi_wdata          = 32'h00000000;
      s_axi_wstrb          = 4'hF;
      s_axi_wvalid         = 1'b0;
      s_axi_bready         = 1'b0;
      s_axi_araddr         = 8'h00;
      s_axi_arvalid        = 1'b0;
      s_axi_rready         = 1'b0;
      coarseFrequencyCheck = 8'h00;
      singleCycleCheck     = 8'h00;
      repeat (2) @(posedge ref_clk);
      rstn <= 1'b1;
      testResetValues();
      testRangeLimits();
      testMasks();
      testSoak();
      finalReport();
   end
endmodule
